// >>> pkg/clock_distribution_pll_pkg.sv
// constants for the clock distribution and pll block
//
// Contract
// - setup changes never glitch or truncate any generated clock or clock output.
// - clock-off write stops system, line interface and pcm clocks.
// - host write or high wake pin restarts stopped clock distribution.
// - pll loop multiplies reference by loop factor; factors 0 to 4 forbidden.
// - output rate equals input times loop factor over predivider times post-scaler; the code caps it at the input rate when that ratio exceeds one.
// - internal divider field plus one divides oscillator inside loop only.
// - after reset pll is disabled and passes its input straight through.
// - run bit rising edge starts acquisition from lowest oscillator frequency, except after standby, which keeps the code.
// - lock flag reads one exactly while the pll is locked; the code sets and clears it two clk cycles after the locked state.
// - freeze puts pll in standby, output stopped until run returns zero.
// - lock flag reads zero during standby.
// - leaving standby relocks within a few reference periods.
// - lock is reached within 2000 reference periods from start.
// - pll stays free for other uses when system clock bypasses it.
// - undivided select without pll select passes the source clock undivided.
package clock_distribution_pll_pkg;

   // ---------------------------------------------------------------
   // widths
   // ---------------------------------------------------------------
   localparam int DIV_W      = 8;
   localparam int INT_DIV_W  = 2;
   localparam int OSC_CODE_W = 10;
   localparam int PHASE_W    = 17;
   localparam int CLK_DIV_W  = 3;

   // ---------------------------------------------------------------
   // counts and limits
   // ---------------------------------------------------------------
   localparam logic [DIV_W-1:0]      LOOP_FACTOR_MIN  = 8'h05;
   localparam logic [2:0]            REACT_REF_COUNT  = 3'h3;
   localparam int                    LOCK_MAX_REF     = 2000;
   localparam logic [CLK_DIV_W-1:0]  CLKOUT_DIV_LAST  = 3'h7;
   localparam logic [CLK_DIV_W-1:0]  SYS_DIV_LAST     = 3'h7;

   // ---------------------------------------------------------------
   // reset values
   // ---------------------------------------------------------------
   localparam logic                  RST_CLOCKS_STOP  = 1'b0;
   localparam logic [OSC_CODE_W-1:0] RST_OSC_CODE     = 10'h000;
   localparam logic [PHASE_W-1:0]    RST_PHASE        = 17'h00000;

   // ---------------------------------------------------------------
   // pll states and clock output modes
   // ---------------------------------------------------------------
   typedef enum logic [4:0] {
      PLL_DISABLED = 5'h01,
      PLL_ACQUIRE  = 5'h02,
      PLL_REACT    = 5'h04,
      PLL_LOCKED   = 5'h08,
      PLL_STANDBY  = 5'h10
   } pll_state_t;

   typedef enum logic [1:0] {
      CLKO_DIV8 = 2'h0,
      CLKO_HI   = 2'h1,
      CLKO_PLL  = 2'h2
   } clkout_mode_t;

endpackage : clock_distribution_pll_pkg

// >>> rtl/clock_distribution_pll.sv
// clock distribution, gating and digital pll control
`timescale 1ns/1ps
`default_nettype none
module clock_distribution_pll (
   // clock and reset
   input  wire logic       clk,
   input  wire logic       arst_n,
   // clock setup
   input  wire logic       sys_from_pll_sel,
   input  wire logic       line_if_clock_sel,
   input  wire logic [1:0] pcm_clock_sel,
   input  wire logic       clkout_undivided_sel,
   input  wire logic       clkout_pll_sel,
   // clock gating
   input  wire logic       clock_off_wr,
   input  wire logic       host_write,
   input  wire logic       wake_pin,
   // pll control
   input  wire logic       pll_run_control,
   input  wire logic       pll_freeze,
   input  wire logic [7:0] pll_pre_div,
   input  wire logic [7:0] pll_loop_factor,
   input  wire logic [1:0] pll_int_div,
   input  wire logic [7:0] pll_post_div,
   // generated clock enables
   output logic            sys_clk_en,
   output logic            line_if_clk_en,
   output logic            pcm_clk_en,
   output logic            clkout_en,
   output logic            pll_out_en,
   // status
   output logic            clocks_stopped,
   output logic            pll_lock
);

   // ---------------------------------------------------------------
   // declarations
   // ---------------------------------------------------------------
   clock_distribution_pll_pkg::pll_state_t   state;
   clock_distribution_pll_pkg::clkout_mode_t clkout_mode;
   clock_distribution_pll_pkg::clkout_mode_t next_clkout_mode;
   logic                                      wake_meta;
   logic                                      wake_sync;
   logic                                      run_q;
   logic                                      keep_code;
   logic [7:0]                                pre_cnt;
   logic                                      ref_tick;
   logic [1:0]                                loop_cnt;
   logic                                      loop_tick;
   logic [9:0]                                osc_code;
   logic [9:0]                                osc_target;
   logic [2:0]                                react_cnt;
   logic [16:0]                               phase;
   logic [16:0]                               phase_sum;
   logic [16:0]                               div_prod;
   logic                                      pll_tick;
   logic                                      lock_int;
   logic                                      lock_meta;
   logic [2:0]                                sys_div;
   logic                                      sys_src_tick;
   logic                                      sys_sel_q;
   logic                                      line_sel_q;
   logic [1:0]                                pcm_sel_q;
   logic [2:0]                                co_cnt;
   logic                                      next_pcm_en;

   // ---------------------------------------------------------------
   // wake pin synchroniser
   // ---------------------------------------------------------------
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         wake_meta <= 1'b0;
         wake_sync <= 1'b0;
      end else begin
         wake_meta <= wake_pin;
         wake_sync <= wake_meta;
      end
   end

   // ---------------------------------------------------------------
   // clock gating
   // ---------------------------------------------------------------
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         clocks_stopped <= clock_distribution_pll_pkg::RST_CLOCKS_STOP;
      end else if (wake_sync || (host_write && !clock_off_wr)) begin
         clocks_stopped <= 1'b0;
      end else if (clock_off_wr) begin
         clocks_stopped <= 1'b1;
      end
   end

   // ---------------------------------------------------------------
   // reference and loop dividers
   // ---------------------------------------------------------------
   assign ref_tick  = (pre_cnt == pll_pre_div);
   assign loop_tick = (loop_cnt == pll_int_div);

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         pre_cnt <= 8'h00;
      end else if (ref_tick || pre_cnt > pll_pre_div) begin
         pre_cnt <= 8'h00;
      end else begin
         pre_cnt <= pre_cnt + 8'h01;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         loop_cnt <= 2'h0;
      end else if (loop_tick || loop_cnt > pll_int_div) begin
         loop_cnt <= 2'h0;
      end else begin
         loop_cnt <= loop_cnt + 2'h1;
      end
   end

   // oscillator runs at loop factor times divider times reference
   assign osc_target = {2'b00, pll_loop_factor}
                       * (10'(pll_int_div) + 10'h001);

   // ---------------------------------------------------------------
   // pll state machine
   // ---------------------------------------------------------------
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         run_q <= 1'b0;
      end else begin
         run_q <= pll_run_control;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         state     <= clock_distribution_pll_pkg::PLL_DISABLED;
         keep_code <= 1'b0;
      end else begin
         unique case (state)
            clock_distribution_pll_pkg::PLL_DISABLED: begin
               if (pll_run_control && !run_q) begin
                  state <= keep_code
                     ? clock_distribution_pll_pkg::PLL_REACT
                     : clock_distribution_pll_pkg::PLL_ACQUIRE;
               end
            end
            clock_distribution_pll_pkg::PLL_ACQUIRE,
            clock_distribution_pll_pkg::PLL_REACT,
            clock_distribution_pll_pkg::PLL_LOCKED: begin
               if (!pll_run_control) begin
                  state     <= clock_distribution_pll_pkg::PLL_DISABLED;
                  keep_code <= 1'b0;
               end else if (pll_freeze) begin
                  state <= clock_distribution_pll_pkg::PLL_STANDBY;
               end else if (state == clock_distribution_pll_pkg::PLL_ACQUIRE
                            && osc_code == osc_target && loop_tick) begin
                  state <= clock_distribution_pll_pkg::PLL_LOCKED;
               end else if (state == clock_distribution_pll_pkg::PLL_REACT
                            && react_cnt ==
                               clock_distribution_pll_pkg::REACT_REF_COUNT) begin
                  state <= clock_distribution_pll_pkg::PLL_LOCKED;
               end
            end
            clock_distribution_pll_pkg::PLL_STANDBY: begin
               if (!pll_run_control) begin
                  state     <= clock_distribution_pll_pkg::PLL_DISABLED;
                  keep_code <= 1'b1;
               end
            end
         endcase
      end
   end

   // ---------------------------------------------------------------
   // frequency search and reactivation count
   // ---------------------------------------------------------------
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         osc_code <= clock_distribution_pll_pkg::RST_OSC_CODE;
      end else if (state == clock_distribution_pll_pkg::PLL_DISABLED
                   && pll_run_control && !run_q && !keep_code) begin
         osc_code <= clock_distribution_pll_pkg::RST_OSC_CODE;
      end else if (state == clock_distribution_pll_pkg::PLL_ACQUIRE
                   && ref_tick && osc_code != osc_target) begin
         osc_code <= (osc_code < osc_target) ? osc_code + 10'h001
                                             : osc_code - 10'h001;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         react_cnt <= 3'h0;
      end else if (state != clock_distribution_pll_pkg::PLL_REACT) begin
         react_cnt <= 3'h0;
      end else if (ref_tick) begin
         react_cnt <= react_cnt + 3'h1;
      end
   end

   // ---------------------------------------------------------------
   // output phase accumulator: n over p times s
   // ---------------------------------------------------------------
   assign div_prod  = 17'(({9'h000, pll_pre_div} + 17'h00001)
                     * ({9'h000, pll_post_div} + 17'h00001));
   assign phase_sum = phase + {9'h000, pll_loop_factor};

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         phase    <= clock_distribution_pll_pkg::RST_PHASE;
         pll_tick <= 1'b0;
      end else if (state != clock_distribution_pll_pkg::PLL_LOCKED) begin
         phase    <= clock_distribution_pll_pkg::RST_PHASE;
         pll_tick <= (state == clock_distribution_pll_pkg::PLL_DISABLED);
      end else begin
         if (phase_sum >= div_prod) begin
            phase    <= (phase_sum - div_prod >= div_prod)
                        ? clock_distribution_pll_pkg::RST_PHASE
                        : phase_sum - div_prod;
            pll_tick <= 1'b1;
         end else begin
            phase    <= phase_sum;
            pll_tick <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         pll_out_en <= 1'b0;
      end else begin
         pll_out_en <= pll_tick;
      end
   end

   // ---------------------------------------------------------------
   // lock flag synchroniser
   // ---------------------------------------------------------------
   assign lock_int = (state == clock_distribution_pll_pkg::PLL_LOCKED);

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         lock_meta <= 1'b0;
         pll_lock  <= 1'b0;
      end else begin
         lock_meta <= lock_int;
         pll_lock  <= lock_meta;
      end
   end

   // ---------------------------------------------------------------
   // system, line interface and pcm clocks
   // ---------------------------------------------------------------
   assign sys_src_tick = sys_sel_q ? pll_tick : 1'b1;

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         sys_div    <= 3'h0;
         sys_sel_q  <= 1'b0;
         line_sel_q <= 1'b0;
         pcm_sel_q  <= 2'h0;
      end else if (sys_src_tick && !clocks_stopped) begin
         sys_div <= sys_div + 3'h1;
         if (sys_div == clock_distribution_pll_pkg::SYS_DIV_LAST) begin
            sys_sel_q  <= sys_from_pll_sel;
            line_sel_q <= line_if_clock_sel;
            pcm_sel_q  <= pcm_clock_sel;
         end
      end
   end

   always_comb begin
      unique case (pcm_sel_q)
         2'h0: next_pcm_en = 1'b1;
         2'h1: next_pcm_en = (sys_div[0] == 1'b0);
         2'h2: next_pcm_en = (sys_div[1:0] == 2'h0);
         2'h3: next_pcm_en = (sys_div == 3'h0);
      endcase
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         sys_clk_en     <= 1'b0;
         line_if_clk_en <= 1'b0;
         pcm_clk_en     <= 1'b0;
      end else begin
         sys_clk_en     <= sys_src_tick && !clocks_stopped;
         line_if_clk_en <= sys_src_tick && !clocks_stopped
                           && (line_sel_q ? sys_div[1:0] == 2'h0
                                          : sys_div[0] == 1'b0);
         pcm_clk_en     <= sys_src_tick && !clocks_stopped && next_pcm_en;
      end
   end

   // ---------------------------------------------------------------
   // clock output
   // ---------------------------------------------------------------
   always_comb begin
      if (clkout_pll_sel) begin
         next_clkout_mode = clock_distribution_pll_pkg::CLKO_PLL;
      end else if (clkout_undivided_sel) begin
         next_clkout_mode = clock_distribution_pll_pkg::CLKO_HI;
      end else begin
         next_clkout_mode = clock_distribution_pll_pkg::CLKO_DIV8;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         co_cnt      <= 3'h0;
         clkout_mode <= clock_distribution_pll_pkg::CLKO_DIV8;
      end else begin
         co_cnt <= co_cnt + 3'h1;
         if (co_cnt == clock_distribution_pll_pkg::CLKOUT_DIV_LAST) begin
            clkout_mode <= next_clkout_mode;
         end
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         clkout_en <= 1'b0;
      end else begin
         unique case (clkout_mode)
            clock_distribution_pll_pkg::CLKO_PLL:
               clkout_en <= pll_tick;
            clock_distribution_pll_pkg::CLKO_HI:
               clkout_en <= 1'b1;
            default:
               clkout_en <= (co_cnt == clock_distribution_pll_pkg::CLKOUT_DIV_LAST);
         endcase
      end
   end

endmodule : clock_distribution_pll
`default_nettype wire

// >>> test/clock_distribution_pll_properties.sv
// port-level assertions for the clock distribution block
`timescale 1ns/1ps
`default_nettype none
module clock_distribution_pll_properties (
   // clock and reset
   input wire logic       clk,
   input wire logic       arst_n,
   // controls
   input wire logic       clkout_undivided_sel,
   input wire logic       clkout_pll_sel,
   input wire logic       clock_off_wr,
   input wire logic       host_write,
   input wire logic       wake_pin,
   input wire logic       pll_run_control,
   input wire logic       pll_freeze,
   input wire logic [7:0] pll_pre_div,
   // outputs
   input wire logic       sys_clk_en,
   input wire logic       line_if_clk_en,
   input wire logic       pcm_clk_en,
   input wire logic       clkout_en,
   input wire logic       pll_out_en,
   input wire logic       clocks_stopped,
   input wire logic       pll_lock
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!arst_n);
   // ------------
   // helpers
   // ------------
   logic [19:0] wait_cnt;
   logic [4:0]  hi_cnt;
   logic        held;
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n)
         held <= 1'b0;
      else
         held <= pll_run_control && (held || pll_freeze);
   end
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n)
         wait_cnt <= 20'h00000;
      else if (!pll_run_control || held || pll_freeze || pll_lock)
         wait_cnt <= 20'h00000;
      else
         wait_cnt <= wait_cnt + 20'h00001;
   end
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n)
         hi_cnt <= 5'h00;
      else if (!clkout_undivided_sel || clkout_pll_sel)
         hi_cnt <= 5'h00;
      else if (hi_cnt != 5'h1F)
         hi_cnt <= hi_cnt + 5'h01;
   end
   // ------------
   // assertions
   // ------------
   a_off_stops: assert property (
      clock_off_wr && !host_write && !$past(wake_pin)
      && !$past(wake_pin, 2) && !$past(wake_pin, 3) |=> clocks_stopped)
      else $error("clock off write did not stop clocks");
   a_gate_outputs: assert property (
      clocks_stopped |=> !sys_clk_en && !line_if_clk_en && !pcm_clk_en)
      else $error("internal clock ticks while stopped");
   a_host_wakes: assert property (
      clocks_stopped && host_write && !clock_off_wr |=> !clocks_stopped)
      else $error("host write did not restart clocks");
   a_pin_wakes: assert property (
      clocks_stopped && wake_pin ##1 wake_pin[*3] |=> !clocks_stopped)
      else $error("wake pin did not restart clocks");
   a_lock_bound: assert property (
      wait_cnt <= 20'(pll_pre_div) * 20'h007D0 + 20'h007D8)
      else $error("pll lock took too long");
   a_idle_bypass: assert property (
      !pll_run_control[*6] |-> pll_out_en && !pll_lock)
      else $error("disabled pll not passing input through");
   a_freeze_drops: assert property (
      (pll_freeze && pll_run_control)[*5] |-> !pll_lock)
      else $error("lock flag high in standby");
   a_freeze_quiet: assert property (
      (pll_freeze && pll_run_control && pll_lock) ##1
      (pll_freeze && pll_run_control)[*3] |-> !pll_out_en)
      else $error("pll output ticks in standby");
   a_run_starts: assert property (
      !pll_run_control[*3] ##1 pll_run_control[*3] |-> ##[0:2] !pll_out_en)
      else $error("run rise did not start acquisition");
   a_undivided_out: assert property (
      hi_cnt >= 5'h12 |-> clkout_en)
      else $error("undivided clock output missing ticks");
endmodule : clock_distribution_pll_properties
`default_nettype wire

// >>> test/tb.sv
// self-checking bench for the clock distribution block
`timescale 1ns/1ps
`default_nettype none
module tb;
   // ------------
   // signals
   // ------------
   logic        clk = 1'b0;
   logic        arst_n, sys_from_pll_sel, line_if_clock_sel;
   logic        clkout_undivided_sel, clkout_pll_sel, clock_off_wr;
   logic        host_write, wake_pin, pll_run_control, pll_freeze;
   logic [1:0]  pcm_clock_sel, pll_int_div;
   logic [7:0]  pll_pre_div, pll_loop_factor, pll_post_div;
   logic        sys_clk_en, line_if_clk_en, pcm_clk_en, clkout_en;
   logic        pll_out_en, clocks_stopped, pll_lock;
   logic [4:0]  ens;
   logic [31:0] seed = 32'h0000D4B1;
   int          mismatches = 0;
   int          num_checks = 0;
   int          n, p, s, t, c;
   assign ens = {sys_clk_en, line_if_clk_en, pcm_clk_en, clkout_en,
                 pll_out_en};
   clock_distribution_pll clock_distribution_pll_i (
      .clk, .arst_n, .sys_from_pll_sel, .line_if_clock_sel, .pcm_clock_sel,
      .clkout_undivided_sel, .clkout_pll_sel, .clock_off_wr, .host_write,
      .wake_pin, .pll_run_control, .pll_freeze, .pll_pre_div,
      .pll_loop_factor, .pll_int_div, .pll_post_div, .sys_clk_en,
      .line_if_clk_en, .pcm_clk_en, .clkout_en, .pll_out_en,
      .clocks_stopped, .pll_lock
   );
   always #12.5 clk = ~clk;
   // ------------
   // helpers
   // ------------
   function logic [31:0] rnd(input int lim);
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed % lim;
   endfunction : rnd
   function int exp_rate(input int cyc);
      return (n >= p * s) ? cyc : cyc * n / (p * s);
   endfunction : exp_rate
   task automatic chk(string what, logic [31:0] exp, logic [31:0] got,
                      int tol = 0);
      num_checks++;
      if ($isunknown(got)
          || (got !== exp && !(tol > 0 && int'(got) - int'(exp) <= tol
                               && int'(exp) - int'(got) <= tol))) begin
         mismatches++;
         $display("unexpected %s: expected %0d, seen %0d", what, exp, got);
      end
   endtask : chk
   task automatic tick(int k);
      repeat (k) @(posedge clk);
      #2;
   endtask : tick
   task automatic count(int sel, int cyc);
      c = 0;
      repeat (cyc) begin
         @(negedge clk);
         c += (ens[sel] === 1'b1);
      end
      tick(1);
   endtask : count
   task automatic wait_lock(int lim);
      t = 0;
      while (pll_lock !== 1'b1 && t < lim) begin
         tick(1);
         t++;
      end
   endtask : wait_lock
   task final_report();
      $display("checks %0d, mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : final_report
   // ------------
   // scenarios
   // ------------
   initial begin
      {arst_n, sys_from_pll_sel, line_if_clock_sel, clkout_undivided_sel,
       clkout_pll_sel, clock_off_wr, host_write, wake_pin, pll_run_control,
       pll_freeze} = '0;
      pcm_clock_sel = 2'h0;
      pll_int_div = 2'h0;
      pll_pre_div = 8'h00;
      pll_loop_factor = 8'h05;
      pll_post_div = 8'h00;
      repeat (6) @(posedge clk);
      #2 arst_n = 1'b1;
      tick(2);
      chk("lock", 0, pll_lock);
      count(0, 64);
      chk("pll passthrough", 64, c);
      count(1, 64);
      chk("clkout div8", 8, c, 1);
      for (int i = 0; i < 8; i++) begin
         line_if_clock_sel = i[2];
         pcm_clock_sel = i[1:0];
         tick(20);
         count(3, 64);
         chk("line clock", i[2] ? 16 : 32, c, 1);
         count(2, 64);
         chk("pcm clock", 64 >> i[1:0], c, 1);
      end
      clkout_undivided_sel = 1'b1;
      tick(20);
      count(1, 64);
      chk("clkout undivided", 64, c);
      for (int k = 0; k < 2; k++) begin
         clock_off_wr = 1'b1;
         host_write = k[0];
         tick(1);
         clock_off_wr = 1'b0;
         host_write = 1'b0;
         tick(2);
         chk("stopped", 1, clocks_stopped);
         count(4, 32);
         chk("sys off", 0, c);
         count(3, 32);
         chk("line off", 0, c);
         count(2, 32);
         chk("pcm off", 0, c);
         host_write = !k[0];
         wake_pin = k[0];
         tick(1);
         host_write = 1'b0;
         tick(4);
         wake_pin = 1'b0;
         chk("restarted", 0, clocks_stopped);
         count(4, 32);
         chk("sys on", 32, c, 1);
      end
      for (int k = 0; k < 3; k++) begin
         n = 5 + int'(rnd(20));
         p = 3 + int'(rnd(8));
         s = 1 + int'(rnd(4));
         pll_loop_factor = 8'(n);
         pll_pre_div = 8'(p - 1);
         pll_post_div = 8'(s - 1);
         pll_int_div = 2'(rnd(4));
         clkout_pll_sel = k[0];
         tick(1);
         pll_run_control = 1'b1;
         wait_lock(2000 * p);
         chk("lock reached", 1, pll_lock);
         chk("search from lowest", 1, t >= (n - 1) * p);
         count(0, 480);
         chk("pll rate", exp_rate(480), c, 2);
         count(4, 64);
         chk("sys from osc", 64, c);
         count(1, 480);
         chk("clkout", k[0] ? exp_rate(480) : 480, c, 2);
         pll_run_control = 1'b0;
         tick(6);
         chk("unlock", 0, pll_lock);
         count(0, 32);
         chk("bypass", 32, c);
      end
      pll_run_control = 1'b1;
      wait_lock(2000 * p);
      sys_from_pll_sel = 1'b1;
      tick(80);
      count(4, 480);
      chk("sys from pll", exp_rate(480), c, 2);
      sys_from_pll_sel = 1'b0;
      tick(80);
      pll_freeze = 1'b1;
      tick(6);
      chk("lock in standby", 0, pll_lock);
      count(0, 64);
      chk("standby output", 0, c);
      pll_run_control = 1'b0;
      tick(4);
      pll_freeze = 1'b0;
      tick(4);
      pll_run_control = 1'b1;
      wait_lock(4 * p + 2);
      chk("fast relock", 1, pll_lock);
      final_report();
   end
   initial begin
      #1ms;
      mismatches++;
      final_report();
   end
endmodule : tb
bind clock_distribution_pll clock_distribution_pll_properties props_i (
   .clk, .arst_n, .clkout_undivided_sel, .clkout_pll_sel, .clock_off_wr,
   .host_write, .wake_pin, .pll_run_control, .pll_freeze, .pll_pre_div,
   .sys_clk_en, .line_if_clk_en, .pcm_clk_en, .clkout_en, .pll_out_en,
   .clocks_stopped, .pll_lock
);
`default_nettype wire
